// file: logic/csilp_lane_ctrl.sv
// Purpose: Lane power sequencing and lane timing selection.
// Assumes: Command pulses come from control logic on ref_clk.
// Notes:   Pixel clock and vertical sync are pins, synchronised here.
// Overview of operation
// - Lanes go to ultra-low power when software requests standby.
// - On entry both data lanes move to that state; the clock lane does so only at depth 1.
// - Entry is taken only after an escape entry command was received.
// - Exit drives Mark-1 for the wake time and then a Stop state.
// - Frame rate is measured from the vertical sync period.
// - The measurement maps to a table valid from 10 to 65 MHz pixel clock.
// - The table assumes either 60 or 30 frames per second.
// - Software can replace the timing set only as a whole, not per parameter.
// - Table selection assumes a blanking ratio of 1.2 over active video.
// - The table has an 800x480 entry, 1056 by 525 totals, at 60 and 30.
// - The table has a 1024x768 entry at 60, 1344 by 806 totals.
// - Depth 0 stops only data lanes; depth 1 also the clock lane and PLL.
// - Programmed timings apply only when external select is set.
`timescale 1ns/1ps
`include "csilp_map.svh"
module csilp_lane_ctrl #(
	parameter int WAKE_CYC = `CSILP_TWAKEUP_CYC,
	parameter int FPS_SPLIT_CYC = `CSILP_CLK_HZ / `CSILP_FPS_SPLIT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Pins from the video source
	input wire logic pixelClockIn,
	input wire logic vertical_sync_in,
	// Control bits and command pulses
	input wire logic standbyRequest,
	input wire logic escapeEntryCmd,
	input wire logic ulpsEntryCmd,
	input wire logic low_power_depth_select,
	input wire logic external_timing_select,
	input wire csilp_pkg::csilp_timing_t programmedTiming,
	// Lane and power outputs
	output csilp_pkg::csilp_lanes_t laneState,
	output logic pllEnable,
	output logic inLowPower,
	// Timing selection outputs
	output csilp_pkg::csilp_timing_t activeTiming,
	output logic fps60,
	output logic rateValid,
	output logic pclkOutOfRange
);

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [1:0] pinSync;
	logic pclkQ;
	logic vsQ;
	logic pclkRise;
	logic vsRise;

	csilp_sync2 #(.WIDTH(2)) pinSyncInst (
		.refClk(ref_clk),
		.rst_n(rst_n),
		.asyncIn({pixelClockIn, vertical_sync_in}),
		.syncOut(pinSync)
	);

	// Second stage feeds the edge detectors, never the first stage.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pclkQ <= 1'b0;
			vsQ <= 1'b0;
		end else begin
			pclkQ <= pinSync[1];
			vsQ <= pinSync[0];
		end
	end

	assign pclkRise = pinSync[1] & ~pclkQ;
	assign vsRise = pinSync[0] & ~vsQ;

	// ------------------------------------------------------------------
	// Frame measurement
	// ------------------------------------------------------------------
	logic [23:0] periodCnt;
	logic [20:0] pixCnt;
	logic [23:0] periodMeas;
	logic [20:0] pixMeas;
	logic seenEdge;
	logic measValid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periodCnt <= 24'h0;
			pixCnt <= 21'h0;
			periodMeas <= 24'h0;
			pixMeas <= 21'h0;
			seenEdge <= 1'b0;
			measValid <= 1'b0;
		end else if (vsRise) begin
			periodMeas <= periodCnt;
			pixMeas <= pixCnt;
			measValid <= seenEdge;
			seenEdge <= 1'b1;
			periodCnt <= 24'h1;
			pixCnt <= pclkRise ? 21'h1 : 21'h0;
		end else begin
			// Counters saturate so a stalled source cannot alias.
			if (periodCnt != `CSILP_PERIOD_MAX) begin
				periodCnt <= periodCnt + 24'h1;
			end
			if (pclkRise && pixCnt != `CSILP_PIX_MAX) begin
				pixCnt <= pixCnt + 21'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Table lookup and timing select
	// ------------------------------------------------------------------
	logic isHigh;
	logic bigArea;
	logic [31:0] pclkHz;
	logic [31:0] areaScaled;
	csilp_pkg::csilp_timing_t lutTiming;

	assign isHigh = periodMeas < 24'(FPS_SPLIT_CYC);
	assign pclkHz = isHigh ? 32'(pixMeas) * 32'(`CSILP_FPS_HI)
		: 32'(pixMeas) * 32'(`CSILP_FPS_LO);
	// active area is the frame divided by 1.2.
	assign areaScaled = 32'(pixMeas) * 32'(`CSILP_BLANK_DEN);
	assign bigArea = areaScaled >= 32'(`CSILP_AREA_MID * `CSILP_BLANK_NUM);

	always_comb begin
		case ({bigArea, isHigh})
			2'b01: lutTiming = `CSILP_TSET_WVGA60;
			2'b00: lutTiming = `CSILP_TSET_WVGA30;
			2'b11: lutTiming = `CSILP_TSET_XGA60;
			default: lutTiming = `CSILP_TSET_OTHER;
		endcase
	end

	// Registered timing outputs; they reload every cycle from the measurement and the external select.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			activeTiming <= '0;
			fps60 <= 1'b0;
			rateValid <= 1'b0;
			pclkOutOfRange <= 1'b0;
		end else begin
			fps60 <= isHigh;
			rateValid <= measValid;
			// flag rates the table cannot serve
			pclkOutOfRange <= measValid &&
				(pclkHz > 32'(`CSILP_PCLK_MAX_HZ) ||
				pclkHz < 32'(`CSILP_PCLK_MIN_HZ));
			activeTiming <= external_timing_select ? programmedTiming
				: lutTiming;
		end
	end

	// ------------------------------------------------------------------
	// Power sequencer
	// ------------------------------------------------------------------
	csilp_pkg::csilp_pwr_t pwrState;
	csilp_pkg::csilp_pwr_t next_pwrState;
	logic [19:0] waitCnt;
	logic waitDone;
	logic deepMode;

	assign waitDone = (pwrState == csilp_pkg::PWR_MARK1)
		? (waitCnt == 20'(WAKE_CYC - 1))
		: (waitCnt == 20'(`CSILP_TSTOP_CYC - 1));

	always_comb begin
		next_pwrState = pwrState;
		case (pwrState)
			csilp_pkg::PWR_HS: begin
				if (standbyRequest && escapeEntryCmd) begin
					next_pwrState = csilp_pkg::PWR_ESC;
				end
			end
			csilp_pkg::PWR_ESC: begin
				if (!standbyRequest) begin
					next_pwrState = csilp_pkg::PWR_STOP;
				end else if (ulpsEntryCmd) begin
					next_pwrState = csilp_pkg::PWR_ULPS;
				end
			end
			csilp_pkg::PWR_ULPS: begin
				if (!standbyRequest) begin
					next_pwrState = csilp_pkg::PWR_MARK1;
				end
			end
			csilp_pkg::PWR_MARK1: begin
				// hold Mark-1 for the wake time
				if (waitDone) begin
					next_pwrState = csilp_pkg::PWR_STOP;
				end
			end
			csilp_pkg::PWR_STOP: begin
				if (waitDone) begin
					next_pwrState = csilp_pkg::PWR_WAITF;
				end
			end
			csilp_pkg::PWR_WAITF: begin
				if (vsRise) begin
					next_pwrState = csilp_pkg::PWR_HS;
				end
			end
			default: next_pwrState = csilp_pkg::PWR_HS;
		endcase
	end

	// State and the wait counter that times Mark-1 and Stop.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwrState <= csilp_pkg::PWR_HS;
			waitCnt <= 20'h0;
		end else begin
			pwrState <= next_pwrState;
			waitCnt <= (next_pwrState != pwrState) ? 20'h0
				: waitCnt + 20'h1;
		end
	end

	// depth is caught at entry so a late write cannot split lanes.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			deepMode <= 1'b0;
		end else if (pwrState == csilp_pkg::PWR_ESC &&
			next_pwrState == csilp_pkg::PWR_ULPS) begin
			deepMode <= low_power_depth_select;
		end
	end

	// Lane outputs follow the next state so they align with pwrState.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			laneState <= '{csilp_pkg::LANE_STOP, csilp_pkg::LANE_STOP,
				csilp_pkg::LANE_STOP};
			pllEnable <= 1'b1;
			inLowPower <= 1'b0;
		end else begin
			inLowPower <= next_pwrState == csilp_pkg::PWR_ULPS;
			case (next_pwrState)
				csilp_pkg::PWR_HS: begin
					laneState <= '{csilp_pkg::LANE_HS, csilp_pkg::LANE_HS,
						csilp_pkg::LANE_HS};
					pllEnable <= 1'b1;
				end
				csilp_pkg::PWR_ULPS: begin
					// all lanes or data lanes only
					laneState.dataLane0 <= csilp_pkg::LANE_ULPS;
					laneState.dataLane1 <= csilp_pkg::LANE_ULPS;
					laneState.clkLane <= (pwrState == csilp_pkg::PWR_ESC
						? low_power_depth_select : deepMode)
						? csilp_pkg::LANE_ULPS : csilp_pkg::LANE_HS;
					pllEnable <= !(pwrState == csilp_pkg::PWR_ESC
						? low_power_depth_select : deepMode);
				end
				csilp_pkg::PWR_MARK1: begin
					laneState.dataLane0 <= csilp_pkg::LANE_MARK1;
					laneState.dataLane1 <= csilp_pkg::LANE_MARK1;
					laneState.clkLane <= deepMode ? csilp_pkg::LANE_MARK1
						: csilp_pkg::LANE_HS;
					pllEnable <= 1'b1;
				end
				default: begin
					laneState.dataLane0 <= csilp_pkg::LANE_STOP;
					laneState.dataLane1 <= csilp_pkg::LANE_STOP;
					laneState.clkLane <= (next_pwrState ==
						csilp_pkg::PWR_ESC || !deepMode)
						? csilp_pkg::LANE_HS : csilp_pkg::LANE_STOP;
					pllEnable <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [19:0] mark1Len;

	// Counts the length of each Mark-1 run for the wake check.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mark1Len <= 20'h0;
		end else begin
			mark1Len <= (laneState.dataLane0 == csilp_pkg::LANE_MARK1)
				? mark1Len + 20'h1 : 20'h0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	standby_entry_a: assert property (
		pwrState == csilp_pkg::PWR_ESC && standbyRequest && ulpsEntryCmd
		|=> inLowPower) else $error("standby did not enter low power");
	all_lanes_ulps_a: assert property (
		inLowPower && deepMode |-> laneState.clkLane ==
		csilp_pkg::LANE_ULPS && laneState.dataLane1 ==
		csilp_pkg::LANE_ULPS) else $error("lanes not all in low power");
	escape_first_a: assert property (
		$rose(inLowPower) |-> $past(pwrState) == csilp_pkg::PWR_ESC)
		else $error("low power entered without escape");
	wake_length_a: assert property (
		$fell(laneState.dataLane0 == csilp_pkg::LANE_MARK1) |->
		mark1Len == 20'(WAKE_CYC) &&
		laneState.dataLane0 == csilp_pkg::LANE_STOP)
		else $error("Mark-1 length wrong");
	rate_class_a: assert property (
		vsRise && seenEdge ##2 1 |-> fps60 ==
		($past(periodCnt, 2) < 24'(FPS_SPLIT_CYC)))
		else $error("frame rate class wrong");
	override_sel_a: assert property (
		external_timing_select |=> activeTiming == $past(programmedTiming))
		else $error("override timing not applied");
	shallow_clock_a: assert property (
		inLowPower && !deepMode |-> pllEnable &&
		laneState.clkLane == csilp_pkg::LANE_HS)
		else $error("clock lane stopped in shallow mode");
	frame_resume_a: assert property (
		pwrState == csilp_pkg::PWR_WAITF && !vsRise |=>
		laneState.dataLane0 != csilp_pkg::LANE_HS)
		else $error("high speed resumed mid frame");

	enter_ulps_c: cover property ($rose(inLowPower));
	deep_wake_c: cover property (deepMode && $rose(pwrState ==
		csilp_pkg::PWR_MARK1));
	override_c: cover property (external_timing_select && rateValid);
	slow_rate_c: cover property (rateValid && !fps60);

endmodule

// file: logic/csilp_map.svh
// Purpose: Named constants for the lane power and timing select block.
// Assumes: Core clock of 125 MHz.
// Notes:   Timing sets in the table are plain defaults for bring-up.
`ifndef CSILP_MAP_SVH
`define CSILP_MAP_SVH

// ----------------------------------------------------------------------
// Clock and wake timing
// ----------------------------------------------------------------------
`define CSILP_CLK_HZ 125000000
`define CSILP_CLK_NS 8
`define CSILP_TWAKEUP_NS 1000000
`define CSILP_TWAKEUP_CYC ((`CSILP_TWAKEUP_NS + `CSILP_CLK_NS - 1) / `CSILP_CLK_NS)
`define CSILP_TSTOP_NS 100
`define CSILP_TSTOP_CYC ((`CSILP_TSTOP_NS + `CSILP_CLK_NS - 1) / `CSILP_CLK_NS)

// ----------------------------------------------------------------------
// Frame rate and pixel clock windows
// ----------------------------------------------------------------------
`define CSILP_FPS_HI 60
`define CSILP_FPS_LO 30
`define CSILP_FPS_SPLIT 45
`define CSILP_PCLK_MIN_HZ 10000000
`define CSILP_PCLK_MAX_HZ 65000000
`define CSILP_PERIOD_MAX 24'hffffff
`define CSILP_PIX_MAX 21'h1fffff

// ----------------------------------------------------------------------
// Table entries and blanking ratio (1.2 = 6/5)
// ----------------------------------------------------------------------
`define CSILP_BLANK_NUM 6
`define CSILP_BLANK_DEN 5
`define CSILP_WVGA_HTOT 1056
`define CSILP_WVGA_VTOT 525
`define CSILP_XGA_HTOT 1344
`define CSILP_XGA_VTOT 806
`define CSILP_WVGA_ACT (800 * 480)
`define CSILP_XGA_ACT (1024 * 768)
`define CSILP_AREA_MID ((`CSILP_WVGA_ACT + `CSILP_XGA_ACT) / 2)
`define CSILP_TSET_WVGA60 36'h2_1432_3214
`define CSILP_TSET_WVGA30 36'h1_0a21_2112
`define CSILP_TSET_XGA60 36'h3_1e43_4316
`define CSILP_TSET_OTHER 36'h3_1e43_4316

`endif

// file: logic/csilp_pkg.sv
// Purpose: Types shared by the lane power and timing select block.
// Assumes: Nothing beyond the map header.
// Notes:   Timing fields follow the lane timing register layout.
package csilp_pkg;

	// ------------------------------------------------------------------
	// Lane line states and power sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LANE_HS = 2'b00,
		LANE_STOP = 2'b01,
		LANE_ULPS = 2'b10,
		LANE_MARK1 = 2'b11
	} csilp_lane_t;

	typedef enum logic [2:0] {
		PWR_HS = 3'b000,
		PWR_ESC = 3'b001,
		PWR_ULPS = 3'b010,
		PWR_MARK1 = 3'b011,
		PWR_STOP = 3'b100,
		PWR_WAITF = 3'b101
	} csilp_pwr_t;

	// ------------------------------------------------------------------
	// Lane timing parameter set
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [4:0] clkPrepare;
		logic [4:0] clkZero;
		logic [2:0] clkTrail;
		logic [3:0] clkPost;
		logic [3:0] hsZero;
		logic [2:0] hsTrail;
		logic [3:0] hsExit;
		logic [4:0] hsPrepare;
		logic [2:0] lpx;
	} csilp_timing_t;

	typedef struct packed {
		csilp_lane_t clkLane;
		csilp_lane_t dataLane0;
		csilp_lane_t dataLane1;
	} csilp_lanes_t;

endpackage

// file: logic/csilp_sync2.sv
// Purpose: Two-stage synchroniser for pins from outside the core clock.
// Assumes: Inputs are static for at least one core clock period.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module csilp_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic refClk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta;

	// Two flops in series; the first is read only by the second.
	always_ff @(posedge refClk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			syncOut <= '0;
		end else begin
			meta <= asyncIn;
			syncOut <= meta;
		end
	end

endmodule

// file: verification/csilp_video_src.sv
// Purpose: Video source model driving pixel clock and vertical sync pins.
// Assumes: Pixel clock period of 125 ns, unrelated to the core clock.
// Notes:   The clock stands still while run is low, so no frame is sent.
`timescale 1ns/1ps
module csilp_video_src (
	// Frame control
	input wire logic run,
	input wire logic [15:0] framePix,
	// Pins toward the bridge
	output logic pixClk,
	output logic vsync
);
	logic [15:0] pixCount;

	initial begin
		pixClk = 1'b0;
		vsync = 1'b0;
		pixCount = 16'h0;
	end

	// Free pixel clock inside frames, held low when the source is idle.
	always begin
		#62.5;
		if (run) begin
			pixClk = ~pixClk;
		end else begin
			pixClk = 1'b0;
		end
	end

	// Frame counter; sync is high for four pixels at each frame start.
	always @(posedge pixClk) begin
		if (pixCount >= framePix - 16'h1) begin
			pixCount <= 16'h0;
		end else begin
			pixCount <= pixCount + 16'h1;
		end
		vsync <= (pixCount < 16'h4);
	end
endmodule

// file: verification/csilp_lane_ctrl_tb_top.sv
// Purpose: Self-checking bench for lane power and timing selection.
// Assumes: Short wake count and short frame-rate split for a quick run.
// Notes:   Frames are far below the big-area class, which is not reached.
`timescale 1ns/1ps
`include "csilp_map.svh"
module csilp_lane_ctrl_tb_top;
	localparam int WAKE = 20;
	logic refClk, rst_n, standby, escCmd, ulpsCmd, depth, extSel, run;
	logic pixClk, vsync, pllOn, lowPwr, fps60, rateValid, pclkBad;
	logic [15:0] framePix;
	csilp_pkg::csilp_timing_t progTiming, actTiming;
	csilp_pkg::csilp_lanes_t lanes;
	int numErrors, checks;

	csilp_video_src src (.run(run), .framePix(framePix),
		.pixClk(pixClk), .vsync(vsync));

	csilp_lane_ctrl #(.WAKE_CYC(WAKE), .FPS_SPLIT_CYC(4000)) uut (
		.ref_clk(refClk), .rst_n(rst_n), .pixelClockIn(pixClk),
		.vertical_sync_in(vsync), .standbyRequest(standby),
		.escapeEntryCmd(escCmd), .ulpsEntryCmd(ulpsCmd),
		.low_power_depth_select(depth),
		.external_timing_select(extSel), .programmedTiming(progTiming),
		.laneState(lanes), .pllEnable(pllOn), .inLowPower(lowPwr),
		.activeTiming(actTiming), .fps60(fps60), .rateValid(rateValid),
		.pclkOutOfRange(pclkBad));

	// Core clock, 8 ns period.
	initial refClk = 1'b0;
	always #4 refClk = ~refClk;

	task automatic check(input string what, input logic [35:0] seen,
		input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrapUp();
		$display("checks %0d errors %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Bounded wait for the sync pin to reach a level.
	task automatic waitVs(input logic level);
		int n;
		n = 0;
		while (vsync !== level) begin
			@(negedge refClk);
			n++;
			if (n > 6000) begin
				numErrors++;
				wrapUp();
			end
		end
	endtask

	// Lane word from a clock lane code and one code for both data lanes.
	function automatic logic [5:0] lset(input logic [1:0] c,
		input logic [1:0] d);
		return {c, d, d};
	endfunction

	// Power command sequence at the given depth, then wake.
	task automatic testUlps(input logic deep);
		int n;
		@(negedge refClk);
		standby = 1'b1;
		ulpsCmd = 1'b1;
		@(negedge refClk);
		ulpsCmd = 1'b0;
		repeat (2) @(negedge refClk);
		check("no escape", {lowPwr, lanes}, {1'b0, lset(2'b00, 2'b00)});
		depth = deep;
		escCmd = 1'b1;
		@(negedge refClk);
		escCmd = 1'b0;
		ulpsCmd = 1'b1;
		@(negedge refClk);
		ulpsCmd = 1'b0;
		repeat (10) @(negedge refClk);
		check("ulps lanes", lanes, lset(deep ? 2'b10 : 2'b00, 2'b10));
		check("pll", pllOn, !deep);
		check("low power", lowPwr, 1'b1);
		standby = 1'b0;
		n = 0;
		while (lanes.dataLane0 !== csilp_pkg::LANE_MARK1 && n < 50) begin
			@(negedge refClk);
			n++;
		end
		if (n >= 50) begin
			numErrors++;
			wrapUp();
		end
		check("mark1 lanes", lanes, lset(deep ? 2'b11 : 2'b00, 2'b11));
		n = 0;
		while (lanes.dataLane0 === csilp_pkg::LANE_MARK1 && n < 500) begin
			@(negedge refClk);
			n++;
		end
		if (n >= 500) begin
			numErrors++;
			wrapUp();
		end
		check("mark1 length", n, WAKE);
		// A shallow standby never stopped the clock lane, so it stays HS.
		check("stop lanes", lanes, lset(deep ? 2'b01 : 2'b00, 2'b01));
		repeat (14) @(negedge refClk);
		waitVs(1'b0);
		waitVs(1'b1);
		check("hold stop", lanes, lset(deep ? 2'b01 : 2'b00, 2'b01));
		repeat (8) @(negedge refClk);
		check("resume hs", lanes, lset(2'b00, 2'b00));
		$display("test ulps depth %0d done", deep);
	endtask

	// Rate measurement for a frame size, then table lookup.
	task automatic testRate(input logic [15:0] pix, input logic hi,
		input logic [35:0] exp);
		framePix = pix;
		repeat (3) begin
			waitVs(1'b0);
			waitVs(1'b1);
		end
		repeat (8) @(negedge refClk);
		check("rate valid", rateValid, 1'b1);
		check("fps60", fps60, hi);
		check("pclk range", pclkBad, 1'b1);
		check("table", actTiming, exp);
		$display("test rate %0d done", pix);
	endtask

	// Override applies only while the external select is set.
	task automatic testOverride();
		@(negedge refClk);
		extSel = 1'b1;
		repeat (3) @(negedge refClk);
		check("override", actTiming, progTiming);
		extSel = 1'b0;
		repeat (3) @(negedge refClk);
		check("internal", actTiming, `CSILP_TSET_WVGA30);
		$display("test override done");
	endtask

	initial begin
		numErrors = 0;
		checks = 0;
		rst_n = 1'b0;
		standby = 1'b0;
		escCmd = 1'b0;
		ulpsCmd = 1'b0;
		depth = 1'b0;
		extSel = 1'b0;
		run = 1'b1;
		framePix = 16'd200;
		progTiming = 36'h5_a5a5_a5a5;
		repeat (8) @(negedge refClk);
		check("reset lanes", lanes, lset(2'b01, 2'b01));
		check("reset flags", {pllOn, lowPwr, rateValid}, 3'b100);
		rst_n = 1'b1;
		repeat (2) @(negedge refClk);
		check("run lanes", lanes, lset(2'b00, 2'b00));
		$display("test reset done");
		testUlps(1'b1);
		testUlps(1'b0);
		testRate(16'd200, 1'b1, `CSILP_TSET_WVGA60);
		testRate(16'd300, 1'b0, `CSILP_TSET_WVGA30);
		testOverride();
		wrapUp();
	end
endmodule
